// *** shared/cbie_consts.svh ***
`ifndef CBIE_CONSTS_SVH
`define CBIE_CONSTS_SVH
// Register byte addresses (word aligned)
`define CBIE_ADDR_PERIPH_EN 12'h000
`define CBIE_ADDR_TX_BUF_EN 12'h004
`define CBIE_ADDR_BUF_EN 12'h008
`define CBIE_ADDR_CTRL 12'h00c
`define CBIE_ADDR_STATUS 12'h010
`define CBIE_ADDR_STATUS_M0 12'h014
`define CBIE_ADDR_STATUS_M1 12'h018
`define CBIE_ADDR_STATUS_M2 12'h01c
`define CBIE_ADDR_EVT_STAT 12'h020
`define CBIE_ADDR_EVT_CLR 12'h024
`define CBIE_ADDR_EVT_EN 12'h028
`define CBIE_ADDR_DIR 12'h02c
// Field positions and masks
`define CBIE_TXEN_MASK 8'h1c
`define CBIE_TXEN_LSB 2
`define CBIE_PE_TX_GRP 4
`define CBIE_PE_RX_GRP 1
`define CBIE_PE_FORCED0_MASK 8'h0c
// Reset values
`define CBIE_EN_RESET 8'h00
`endif

// *** shared/cbie_gate_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface cbie_gate_if;
   logic enh_mode;
   logic tx_grp_en;
   logic rx_grp_en;
   logic [2:0] tx_en;
   logic [7:0] buf_en;
   logic [5:0] prog_is_tx;
   logic [2:0] tx_raw;
   logic [7:0] buf_raw;
   logic [10:0] gated;
   modport ctl (output enh_mode, tx_grp_en, rx_grp_en, tx_en, buf_en, prog_is_tx,
      tx_raw, buf_raw, input gated);
   modport gate (input enh_mode, tx_grp_en, rx_grp_en, tx_en, buf_en, prog_is_tx,
      tx_raw, buf_raw, output gated);
endinterface
`default_nettype wire

// *** shared/cbie_pkg.sv ***
`default_nettype none
package cbie_pkg;
   // Controller operating mode
   typedef enum logic [2:0]
   {
      CBIE_MODE0 = 3'b001,
      CBIE_MODE1 = 3'b010,
      CBIE_MODE2 = 3'b100
   } cbie_mode_t;
endpackage
`default_nettype wire

// *** tb/cbie_top_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cbie_consts.svh"
module cbie_top_tb_top;
   logic core_clk_in;
   logic rst_in;
   logic psel_in;
   logic penable_in;
   logic pwrite_in;
   logic [11:0] paddr_in;
   logic [31:0] pwdata_in;
   logic [31:0] prdata_out;
   logic pready_out;
   logic pslverr_out;
   logic [2:0] tx_done_in;
   logic [7:0] buf_event_in;
   logic [7:0] ctrl_status_in;
   logic irq_out;
   int bad_count;
   int num_checks;

   // Device under test
   cbie_top i_cbie_top
   (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .psel_in(psel_in),
      .penable_in(penable_in),
      .pwrite_in(pwrite_in),
      .paddr_in(paddr_in),
      .pwdata_in(pwdata_in),
      .prdata_out(prdata_out),
      .pready_out(pready_out),
      .pslverr_out(pslverr_out),
      .tx_done_in(tx_done_in),
      .buf_event_in(buf_event_in),
      .ctrl_status_in(ctrl_status_in),
      .irq_out(irq_out)
   );

   // Clock at 100 MHz
   initial
   begin
      core_clk_in = 1'b0;
      forever #5 core_clk_in = ~core_clk_in;
   end

   // Compares a value seen against its expectation
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Prints the counts and the verdict, then stops
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // One APB transfer: setup, then access until pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] rd);
      @(posedge core_clk_in);
      psel_in <= 1'b1;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge core_clk_in);
      penable_in <= 1'b1;
      do @(posedge core_clk_in); while (pready_out !== 1'b1);
      rd = prdata_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rd;
      apb(1'b1, a, d, rd);
   endtask

   task automatic chk_rd(input string name, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      apb(1'b0, a, 32'h0, rd);
      check(name, rd, exp);
   endtask

   // One-cycle event pulse, then time for status and irq to settle
   task automatic pulse(input logic [2:0] t, input logic [7:0] b);
      @(posedge core_clk_in);
      tx_done_in <= t;
      buf_event_in <= b;
      @(posedge core_clk_in);
      tx_done_in <= 3'h0;
      buf_event_in <= 8'h00;
      repeat (3) @(posedge core_clk_in);
      #1;
   endtask

   // Main sequence
   initial
   begin
      bad_count = 0;
      num_checks = 0;
      rst_in = 1'b1;
      psel_in = 1'b0;
      penable_in = 1'b0;
      pwrite_in = 1'b0;
      paddr_in = 12'h000;
      pwdata_in = 32'h0;
      tx_done_in = 3'h0;
      buf_event_in = 8'h00;
      ctrl_status_in = 8'h5a;
      repeat (16) @(posedge core_clk_in);
      rst_in <= 1'b0;
      repeat (2) @(posedge core_clk_in);
      chk_rd("tx enables reset", `CBIE_ADDR_TX_BUF_EN, 32'h0);
      chk_rd("buf enables reset", `CBIE_ADDR_BUF_EN, 32'h0);
      wr(`CBIE_ADDR_TX_BUF_EN, 32'hff);
      chk_rd("tx enables mode 0", `CBIE_ADDR_TX_BUF_EN, 32'h0);
      wr(`CBIE_ADDR_CTRL, 32'h1);
      wr(`CBIE_ADDR_TX_BUF_EN, 32'hffffffff);
      chk_rd("tx enables", `CBIE_ADDR_TX_BUF_EN, 32'h1c);
      wr(`CBIE_ADDR_BUF_EN, 32'hff);
      chk_rd("buf enables", `CBIE_ADDR_BUF_EN, 32'hff);
      wr(`CBIE_ADDR_PERIPH_EN, 32'hff);
      chk_rd("periph enables", `CBIE_ADDR_PERIPH_EN, 32'hf3);
      for (int i = 0; i < 4; i++)
         chk_rd("status mirror", `CBIE_ADDR_STATUS + 12'(4 * i), 32'h5a);
      wr(12'h030, 32'hff);
      chk_rd("unmapped", 12'h030, 32'h0);
      chk_rd("unmapped top", 12'hffc, 32'h0);
      wr(`CBIE_ADDR_EVT_EN, 32'h7ff);
      wr(`CBIE_ADDR_DIR, 32'h01);
      // Transmit buffer 1 with both enables set
      pulse(3'b010, 8'h00);
      chk_rd("tx1 status", `CBIE_ADDR_EVT_STAT, 32'h002);
      check("irq set", {31'h0, irq_out}, 32'h1);
      wr(`CBIE_ADDR_EVT_CLR, 32'h7ff);
      repeat (2) @(posedge core_clk_in);
      #1;
      check("irq cleared", {31'h0, irq_out}, 32'h0);
      // Buffer 0 disabled individually
      wr(`CBIE_ADDR_TX_BUF_EN, 32'h18);
      pulse(3'b001, 8'h00);
      chk_rd("tx0 masked", `CBIE_ADDR_EVT_STAT, 32'h0);
      // Receive group only
      wr(`CBIE_ADDR_PERIPH_EN, 32'h02);
      pulse(3'b100, 8'h00);
      chk_rd("tx group off", `CBIE_ADDR_EVT_STAT, 32'h0);
      pulse(3'b000, 8'h01);
      chk_rd("rx0 status", `CBIE_ADDR_EVT_STAT, 32'h008);
      pulse(3'b000, 8'h04);
      chk_rd("prog0 tx gated", `CBIE_ADDR_EVT_STAT, 32'h008);
      // Transmit group only
      wr(`CBIE_ADDR_PERIPH_EN, 32'h10);
      pulse(3'b000, 8'h04);
      chk_rd("prog0 tx status", `CBIE_ADDR_EVT_STAT, 32'h028);
      pulse(3'b000, 8'h02);
      chk_rd("rx group off", `CBIE_ADDR_EVT_STAT, 32'h028);
      wr(`CBIE_ADDR_EVT_EN, 32'h0);
      repeat (2) @(posedge core_clk_in);
      #1;
      check("irq masked", {31'h0, irq_out}, 32'h0);
      wr(`CBIE_ADDR_EVT_CLR, 32'h7ff);
      // Back in mode 0 no buffer event is forwarded, whatever the per-buffer enables hold
      wr(`CBIE_ADDR_CTRL, 32'h0);
      wr(`CBIE_ADDR_PERIPH_EN, 32'hff);
      pulse(3'b111, 8'hff);
      chk_rd("mode 0 events", `CBIE_ADDR_EVT_STAT, 32'h0);
      // Mode 2 brings the stored enables back; forced bits clear on entry
      wr(`CBIE_ADDR_CTRL, 32'h2);
      chk_rd("mode 2", `CBIE_ADDR_CTRL, 32'h2);
      chk_rd("periph forced", `CBIE_ADDR_PERIPH_EN, 32'hf3);
      pulse(3'b100, 8'h00);
      chk_rd("mode 2 tx2", `CBIE_ADDR_EVT_STAT, 32'h004);
      // Mode code 3 falls back to mode 0
      wr(`CBIE_ADDR_CTRL, 32'h3);
      chk_rd("mode code 3", `CBIE_ADDR_CTRL, 32'h0);
      check("no slave error", {31'h0, pslverr_out}, 32'h0);
      end_of_test();
   end

   // Watchdog against a hung transfer
   initial
   begin
      #200us;
      bad_count++;
      end_of_test();
   end
endmodule
`default_nettype wire

// *** verilog/cbie_gate.sv ***
`timescale 1ns/1ps
`default_nettype none
module cbie_gate
(
   // Gating inputs and result
   cbie_gate_if.gate g
);
   // Dedicated transmit buffers gated by the transmit group enable
   genvar i;
   generate
      for (i = 0; i < 3; i++)
      begin : g_tx
         assign g.gated[i] = g.enh_mode & g.tx_grp_en & g.tx_en[i] & g.tx_raw[i]; // R04
      end
      // Dedicated receive buffers use the receive group
      for (i = 0; i < 2; i++)
      begin : g_rx
         assign g.gated[3+i] = g.enh_mode & g.rx_grp_en & g.buf_en[i] & g.buf_raw[i]; // R12
      end
      // Programmable buffers pick the group from their direction
      for (i = 0; i < 6; i++)
      begin : g_prog
         assign g.gated[5+i] = g.enh_mode & g.buf_en[2+i] & g.buf_raw[2+i] &
            (g.prog_is_tx[i] ? g.tx_grp_en : g.rx_grp_en); // R14
      end
   endgenerate
endmodule
`default_nettype wire

// *** verilog/cbie_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cbie_consts.svh"
// Behaviour
// R01: Transmit enable bits 4..2 writable
// R02: Other transmit enable bits read zero
// R03: Per-buffer enables work only in modes 1,2
// R04: Transmit interrupt needs buffer and group enable
// R05: Buffer enable bits 7..2 programmable buffers
// R06: Buffer enable bits 1..0 dedicated receive
// R07: Buffer enables forwarded only with group enable
// R08: All enables clear at reset
// R09: Status readable at mirror addresses
// R10: Unmapped addresses read zero, ignore writes
// R11: Transmit group gates all transmit buffers
// R12: Receive group gates all receive buffers
// R13: Peripheral transmit 1,0 enables forced zero; the code forces them in modes 1,2 only
// R14: Programmable buffer gated by its direction
module cbie_top
(
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Buffer events from the protocol engine, one-cycle pulses
   input wire logic [2:0] tx_done_in,
   input wire logic [7:0] buf_event_in,
   // Controller status from the protocol engine
   input wire logic [7:0] ctrl_status_in,
   // Interrupt
   output logic irq_out
);
   logic [7:0] periph_en_q;
   logic [7:0] tx_en_q;
   logic [7:0] buf_en_q;
   logic [1:0] mode_sel_q;
   logic [5:0] dir_q;
   logic [10:0] evt_stat_q;
   logic [10:0] evt_en_q;
   logic [10:0] evt_set;
   logic [10:0] evt_clr;
   logic [31:0] rdata_d;
   logic wr_en;
   logic rd_en;
   logic irq_d;
   cbie_pkg::cbie_mode_t mode;
   cbie_gate_if gi ();

   // Write strobe in the access phase, read strobe in setup; slave answers with zero wait states
   assign wr_en = psel_in & penable_in & pwrite_in;
   assign rd_en = psel_in & ~penable_in & ~pwrite_in;

   // Mode decode from the control register
   always_comb
   begin
      unique case (mode_sel_q)
         2'd1: mode = cbie_pkg::CBIE_MODE1;
         2'd2: mode = cbie_pkg::CBIE_MODE2;
         default: mode = cbie_pkg::CBIE_MODE0;
      endcase
   end

   // Gating connections
   assign gi.enh_mode = (mode != cbie_pkg::CBIE_MODE0); // R03
   assign gi.tx_grp_en = periph_en_q[`CBIE_PE_TX_GRP]; // R11
   assign gi.rx_grp_en = periph_en_q[`CBIE_PE_RX_GRP]; // R12
   assign gi.tx_en = tx_en_q[4:2];
   assign gi.buf_en = buf_en_q;
   assign gi.prog_is_tx = dir_q;
   assign gi.tx_raw = tx_done_in;
   assign gi.buf_raw = buf_event_in;

   cbie_gate u_gate
   (
      .g(gi.gate)
   );

   // Peripheral enable register; transmit 1,0 enables forced low in enhanced modes
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
         periph_en_q <= `CBIE_EN_RESET;
      else if (wr_en && paddr_in == `CBIE_ADDR_PERIPH_EN)
         periph_en_q <= gi.enh_mode ? (pwdata_in[7:0] & ~`CBIE_PE_FORCED0_MASK)
            : pwdata_in[7:0]; // R13
      else if (gi.enh_mode)
         periph_en_q <= periph_en_q & ~`CBIE_PE_FORCED0_MASK; // R13
   end

   // Transmit buffer enables, only bits 4..2 exist
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
         tx_en_q <= `CBIE_EN_RESET; // R08
      else if (wr_en && paddr_in == `CBIE_ADDR_TX_BUF_EN && gi.enh_mode) // R03
         tx_en_q <= pwdata_in[7:0] & `CBIE_TXEN_MASK; // R01 R02
   end

   // Buffer enables: programmable 7..2, dedicated receive 1..0
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
         buf_en_q <= `CBIE_EN_RESET; // R08
      else if (wr_en && paddr_in == `CBIE_ADDR_BUF_EN && gi.enh_mode) // R03
         buf_en_q <= pwdata_in[7:0]; // R05 R06
   end

   // Mode and programmable buffer direction registers
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         mode_sel_q <= 2'h0;
         dir_q <= 6'h00;
      end
      else if (wr_en && paddr_in == `CBIE_ADDR_CTRL)
         mode_sel_q <= (pwdata_in[1:0] == 2'h3) ? 2'h0 : pwdata_in[1:0];
      else if (wr_en && paddr_in == `CBIE_ADDR_DIR)
         dir_q <= pwdata_in[5:0];
   end

   // Sticky interrupt status; a new event wins over a clear
   assign evt_set = gi.gated; // R07
   assign evt_clr = (wr_en && paddr_in == `CBIE_ADDR_EVT_CLR) ? pwdata_in[10:0] : 11'h000;
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
         evt_stat_q <= 11'h000;
      else
         evt_stat_q <= (evt_stat_q & ~evt_clr) | evt_set;
   end

   // Interrupt enable register
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
         evt_en_q <= 11'h000;
      else if (wr_en && paddr_in == `CBIE_ADDR_EVT_EN)
         evt_en_q <= pwdata_in[10:0];
   end

   // Read mux; mirrors return the status, unmapped reads zero
   always_comb
   begin
      rdata_d = 32'h0000_0000; // R10
      unique case (paddr_in)
         `CBIE_ADDR_PERIPH_EN: rdata_d = {24'h0, periph_en_q};
         `CBIE_ADDR_TX_BUF_EN: rdata_d = {24'h0, tx_en_q & `CBIE_TXEN_MASK}; // R02
         `CBIE_ADDR_BUF_EN: rdata_d = {24'h0, buf_en_q};
         `CBIE_ADDR_CTRL: rdata_d = {30'h0, mode_sel_q};
         `CBIE_ADDR_STATUS,
         `CBIE_ADDR_STATUS_M0,
         `CBIE_ADDR_STATUS_M1,
         `CBIE_ADDR_STATUS_M2: rdata_d = {24'h0, ctrl_status_in}; // R09
         `CBIE_ADDR_EVT_STAT: rdata_d = {21'h0, evt_stat_q};
         `CBIE_ADDR_EVT_EN: rdata_d = {21'h0, evt_en_q};
         `CBIE_ADDR_DIR: rdata_d = {26'h0, dir_q};
         default: rdata_d = 32'h0000_0000; // R10
      endcase
   end

   // Read data registered in setup so it is valid in the access phase
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
         prdata_out <= 32'h0000_0000;
      else if (rd_en)
         prdata_out <= rdata_d;
   end

   // Fixed bus answer flags
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
      end
      else
      begin
         pready_out <= 1'b1;
         pslverr_out <= 1'b0;
      end
   end

   // Interrupt line
   assign irq_d = |(evt_stat_q & evt_en_q);
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
         irq_out <= 1'b0;
      else
         irq_out <= irq_d;
   end

   // Checks
   txgate_needs_grp_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (gi.gated[2:0] != 3'h0) |-> (gi.tx_grp_en && gi.enh_mode))
      else $error("tx interrupt passed without group enable"); // R04
   txen_reserved_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (tx_en_q & ~`CBIE_TXEN_MASK) == 8'h00)
      else $error("tx enable reserved bit set"); // R02
   txen_write_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (wr_en && paddr_in == `CBIE_ADDR_TX_BUF_EN && gi.enh_mode)
      |=> tx_en_q[4:2] == $past(pwdata_in[4:2]))
      else $error("tx enable write lost"); // R01
   mode0_noupd_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (!gi.enh_mode && !$past(gi.enh_mode)) |-> (gi.gated == 11'h000))
      else $error("interrupt forwarded in mode 0"); // R03
   buf_write_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (wr_en && paddr_in == `CBIE_ADDR_BUF_EN && gi.enh_mode)
      |=> buf_en_q == $past(pwdata_in[7:0]))
      else $error("buffer enable write lost"); // R05
   rxgate_needs_grp_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (gi.gated[4:3] != 2'h0) |-> (gi.rx_grp_en && buf_en_q[1:0] != 2'h0))
      else $error("rx interrupt passed without enables"); // R06
   forced_zero_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      $past(gi.enh_mode) && gi.enh_mode |-> (periph_en_q & `CBIE_PE_FORCED0_MASK) == 8'h00)
      else $error("forced transmit enables not zero"); // R13
   mirror_read_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (rd_en && paddr_in == `CBIE_ADDR_STATUS_M1) |=> prdata_out == {24'h0, $past(ctrl_status_in)})
      else $error("status mirror mismatch"); // R09
   unmapped_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (rd_en && paddr_in > `CBIE_ADDR_DIR) |=> prdata_out == 32'h0000_0000)
      else $error("unmapped read not zero"); // R10
   prog_dir_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      gi.gated[5] |-> (dir_q[0] ? gi.tx_grp_en : gi.rx_grp_en))
      else $error("programmable buffer wrong group"); // R14
   irq_follow_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      ##1 irq_out == $past(irq_d))
      else $error("irq does not follow enabled status"); // R07
   // Group enables gate every buffer of their direction
   txgrp_all_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !gi.tx_grp_en |-> ((gi.gated[2:0] == 3'h0) && ((gi.gated[10:5] & dir_q) == 6'h00)))
      else $error("transmit buffer interrupt with group off"); // R11
   rxgrp_all_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !gi.rx_grp_en |-> ((gi.gated[4:3] == 2'h0) && ((gi.gated[10:5] & ~dir_q) == 6'h00)))
      else $error("receive buffer interrupt with group off"); // R12
   evt_sticky_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (gi.gated != 11'h000) |=> ((evt_stat_q & $past(gi.gated)) == $past(gi.gated)))
      else $error("event lost against a clear"); // R07
endmodule
`default_nettype wire
